// File: logic/rtd_top.sv
// Touch digitizer core: register file, conversion sequencer and interrupt.
// Operation
// - Interrupt output high and held until cleared.
// - Touch output low when touched, else high.
// - Select and strobes active low; access needs both.
// - Eight eight-bit registers on three address lines.
// - Any register read clears pending interrupt.
// - Read during interrupt raising leaves it set.
// - Control register enables interrupt sources.
// - Control bits 2/3 and 6/7 are OR'd.
// - Bits 2/3 enable touch-change interrupt.
// - Rate register sets periodic conversion interval.
// - Rate spans 203 to 13 points per second.
// - On touch convert X, Y, store, interrupt.
// - Touch gone returns to monitoring state.
// - Coordinates are twelve bits split over registers.
// - Reset clears 0,1,6; rate loads 32.
// - Writing power-down to control clears interrupt.
// - Wait 1 ms after interrupt before converting.
`timescale 1ns/10ps
`default_nettype none
module rtd_top #(
  parameter int SETTLE_CYC = rtd_pkg::SETTLE_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic reg_sel_hi,
  input wire logic reg_sel_mid,
  input wire logic reg_sel_lo,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic int_out,
  output logic touch_n,
  input wire logic touch_sense,
  output logic adc_req,
  output logic adc_sel_y,
  input wire logic adc_done,
  input wire logic [11:0] adc_data
);
  rtd_host_if hp ();

  rtd_host_port u_port (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .cs_n(cs_n),
    .rd_n(rd_n),
    .wr_n(wr_n),
    .reg_sel_hi(reg_sel_hi),
    .reg_sel_mid(reg_sel_mid),
    .reg_sel_lo(reg_sel_lo),
    .data_in(data_in),
    .hp(hp.port)
  );

  rtd_pkg::rtd_state_t state;
  rtd_pkg::rtd_state_t next_state;
  logic touch_meta;
  logic touched;
  logic touched_q;
  logic [11:0] x_val;
  logic [11:0] y_val;
  logic [7:0] scratch_a;
  logic [7:0] scratch_b;
  logic [7:0] ctrl;
  logic [7:0] rate;
  logic [7:0] rd_mux;
  logic [11:0] tick_cnt;
  logic [8:0] tick_num;
  logic [13:0] settle_cnt;
  logic [3:0] raise_cnt;
  logic conv_en;
  logic touch_int_en;
  logic raise_evt;
  logic raising;
  logic interval_done;
  logic settle_done;
  logic pd_write;

  // Touch comparator is analog and asynchronous to sys_clk.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      touch_meta <= 1'b0;
      touched <= 1'b0;
      touched_q <= 1'b0;
      touch_n <= 1'b1;
    end else begin
      touch_meta <= touch_sense;
      touched <= touch_meta;
      touched_q <= touched;
      touch_n <= ~touched;
    end
  end

  assign conv_en = ctrl[rtd_pkg::CTRL_ENABLE_BIT]
                   & (ctrl[rtd_pkg::CTRL_PERIODIC_A_BIT] | ctrl[rtd_pkg::CTRL_PERIODIC_B_BIT]);
  assign touch_int_en = ctrl[rtd_pkg::CTRL_TOUCH_INT_A_BIT]
                        | ctrl[rtd_pkg::CTRL_TOUCH_INT_B_BIT];
  // Intervals below the ninth count would outrun the conversion itself; they are not guarded.
  assign interval_done = {1'b0, tick_num} >= ({2'b00, rate} + {1'b0, rtd_pkg::RATE_OFFSET});
  assign settle_done = settle_cnt >= 14'(SETTLE_CYC);
  assign pd_write = hp.wr_pulse && hp.addr == rtd_pkg::ADDR_CTRL
                    && hp.wdata == rtd_pkg::CTRL_POWER_DOWN;

  always_comb begin
    next_state = state;
    unique case (state)
      rtd_pkg::ST_MONITOR: if (conv_en && touched && settle_done) begin
        next_state = rtd_pkg::ST_CONV_X;
      end
      rtd_pkg::ST_CONV_X: if (adc_done) next_state = rtd_pkg::ST_CONV_Y;
      rtd_pkg::ST_CONV_Y: if (adc_done) next_state = rtd_pkg::ST_SETTLE;
      rtd_pkg::ST_SETTLE: begin
        if (!touched || !conv_en) begin
          next_state = rtd_pkg::ST_MONITOR;
        end else if (settle_done && interval_done) begin
          next_state = rtd_pkg::ST_CONV_X;
        end
      end
      default: next_state = rtd_pkg::ST_MONITOR;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= rtd_pkg::ST_MONITOR;
      adc_req <= 1'b0;
      adc_sel_y <= 1'b0;
    end else begin
      state <= next_state;
      adc_req <= next_state == rtd_pkg::ST_CONV_X || next_state == rtd_pkg::ST_CONV_Y;
      adc_sel_y <= next_state == rtd_pkg::ST_CONV_Y;
    end
  end

  // Interval runs from each X start; settle runs from the end of Y, when the interrupt rises.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 12'h000;
      tick_num <= 9'h000;
      settle_cnt <= 14'h0000;
    end else begin
      if (next_state == rtd_pkg::ST_CONV_X && state != rtd_pkg::ST_CONV_X) begin
        tick_cnt <= 12'h000;
        tick_num <= 9'h000;
      end else if (tick_cnt == 12'(rtd_pkg::RATE_TICK_CYC - 1)) begin
        tick_cnt <= 12'h000;
        if (tick_num != 9'h1FF) tick_num <= tick_num + 9'h001;
      end else begin
        tick_cnt <= tick_cnt + 12'h001;
      end
      if (state == rtd_pkg::ST_CONV_Y && adc_done) begin
        settle_cnt <= 14'h0000;
      end else if (!settle_done) begin
        settle_cnt <= settle_cnt + 14'h0001;
      end
    end
  end

  // Coordinates land only once the whole conversion result is in.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      x_val <= 12'h000;
      y_val <= 12'h000;
    end else if (adc_done) begin
      if (state == rtd_pkg::ST_CONV_X) x_val <= adc_data;
      if (state == rtd_pkg::ST_CONV_Y) y_val <= adc_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= rtd_pkg::CTRL_RESET;
      rate <= rtd_pkg::RATE_RESET;
      scratch_a <= 8'h00;
      scratch_b <= 8'h00;
    end else if (hp.wr_pulse) begin
      unique case (hp.addr)
        rtd_pkg::ADDR_CTRL: ctrl <= hp.wdata;
        rtd_pkg::ADDR_RATE: rate <= hp.wdata;
        rtd_pkg::ADDR_SCRATCH_A: scratch_a <= hp.wdata;
        rtd_pkg::ADDR_SCRATCH_B: scratch_b <= hp.wdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    unique case (hp.addr)
      rtd_pkg::ADDR_X_LO: rd_mux = x_val[7:0];
      rtd_pkg::ADDR_X_HI: rd_mux = {3'h0, touched, x_val[11:8]};
      rtd_pkg::ADDR_Y_LO: rd_mux = y_val[7:0];
      rtd_pkg::ADDR_Y_HI: rd_mux = {4'h0, y_val[11:8]};
      rtd_pkg::ADDR_SCRATCH_A: rd_mux = scratch_a;
      rtd_pkg::ADDR_SCRATCH_B: rd_mux = scratch_b;
      rtd_pkg::ADDR_CTRL: rd_mux = ctrl;
      default: rd_mux = rate;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= 8'h00;
      data_oe <= 1'b0;
    end else begin
      data_out <= hp.rd_act ? rd_mux : 8'h00;
      data_oe <= hp.rd_act;
    end
  end

  assign raise_evt = (state == rtd_pkg::ST_CONV_Y && adc_done && ctrl[rtd_pkg::CTRL_CONV_INT_BIT])
                     | (touched != touched_q && touch_int_en);
  assign raising = raise_evt || raise_cnt != 4'h0;

  // Raising takes a fixed internal delay; a read meeting it cannot clear it.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      raise_cnt <= 4'h0;
      int_out <= 1'b0;
    end else begin
      if (raise_evt) begin
        raise_cnt <= 4'(rtd_pkg::RAISE_CYC);
      end else if (raise_cnt != 4'h0) begin
        raise_cnt <= raise_cnt - 4'h1;
      end
      if (raise_cnt == 4'h1) begin
        int_out <= 1'b1;
      end else if (hp.rd_start && !raising) begin
        int_out <= 1'b0;
      end else if (pd_write) begin
        int_out <= 1'b0;
      end
    end
  end
endmodule : rtd_top
`default_nettype wire

// File: logic/rtd_pkg.sv
// Shared constants for the resistive touch digitizer.
`default_nettype none
package rtd_pkg;
  // Register indices on the three-bit select.
  localparam logic [2:0] ADDR_X_LO = 3'h0;
  localparam logic [2:0] ADDR_X_HI = 3'h1;
  localparam logic [2:0] ADDR_Y_LO = 3'h2;
  localparam logic [2:0] ADDR_Y_HI = 3'h3;
  localparam logic [2:0] ADDR_SCRATCH_A = 3'h4;
  localparam logic [2:0] ADDR_SCRATCH_B = 3'h5;
  localparam logic [2:0] ADDR_CTRL = 3'h6;
  localparam logic [2:0] ADDR_RATE = 3'h7;
  // Control register fields.
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_CONV_INT_BIT = 1;
  localparam int CTRL_TOUCH_INT_A_BIT = 2;
  localparam int CTRL_TOUCH_INT_B_BIT = 3;
  localparam int CTRL_PERIODIC_A_BIT = 6;
  localparam int CTRL_PERIODIC_B_BIT = 7;
  // High-byte status field.
  localparam int X_HI_TOUCH_BIT = 4;
  // Reset values and the power-down command value.
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] RATE_RESET = 8'h20;
  localparam logic [7:0] CTRL_POWER_DOWN = 8'h00;
  // Timing and converter width.
  localparam int CLK_PERIOD_NS = 100;
  localparam int RATE_TICK_NS = 290000;
  localparam int RATE_TICK_CYC = RATE_TICK_NS / CLK_PERIOD_NS;
  localparam logic [8:0] RATE_OFFSET = 9'h008;
  localparam int RAISE_NS = 100;
  localparam int RAISE_CYC = (RAISE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_US = 1000;
  localparam int SETTLE_CYC = (SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADC_WIDTH = 12;

  typedef enum logic [3:0] {
    ST_MONITOR = 4'b0001,
    ST_CONV_X = 4'b0010,
    ST_CONV_Y = 4'b0100,
    ST_SETTLE = 4'b1000
  } rtd_state_t;
endpackage : rtd_pkg
`default_nettype wire

// File: logic/rtd_host_if.sv
// Decoded host port accesses passed from the pin front end to the core.
`timescale 1ns/10ps
`default_nettype none
interface rtd_host_if;
  logic rd_act;
  logic rd_start;
  logic wr_pulse;
  logic [2:0] addr;
  logic [7:0] wdata;
  modport port (output rd_act, output rd_start, output wr_pulse, output addr, output wdata);
  modport core (input rd_act, input rd_start, input wr_pulse, input addr, input wdata);
endinterface : rtd_host_if
`default_nettype wire

// File: logic/rtd_host_port.sv
// Host parallel port front end: pin synchronisers and strobe decoding.
`timescale 1ns/10ps
`default_nettype none
module rtd_host_port (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic reg_sel_hi,
  input wire logic reg_sel_mid,
  input wire logic reg_sel_lo,
  input wire logic [7:0] data_in,
  rtd_host_if.port hp
);
  logic [13:0] meta;
  logic [13:0] sync;
  logic rd_q;
  logic wr_q;
  logic rd_now;
  logic wr_now;
  logic wr_pulse;
  logic [10:0] wr_hold;

  // Strobes, select and data are asynchronous to sys_clk; all pass two stages.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      // Idle means no select and no strobe, so nothing is seen as an access after reset.
      meta <= 14'h0000;
      sync <= 14'h0000;
    end else begin
      meta <= {~cs_n, ~rd_n, ~wr_n, reg_sel_hi, reg_sel_mid, reg_sel_lo, data_in};
      sync <= meta;
    end
  end

  // An access needs chip select together with a strobe.
  assign rd_now = ~sync[13] & ~sync[12] ? 1'b0 : (sync[13] & sync[12]);
  assign wr_now = sync[13] & sync[11];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end else begin
      rd_q <= rd_now;
      wr_q <= wr_now;
    end
  end

  // Select and data are sampled while the write is seen and held once it ends, so a host that moves them
  // as it lifts the strobe still writes what it meant.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_hold <= 11'h000;
    end else if (wr_now) begin
      wr_hold <= sync[10:0];
    end
  end

  assign wr_pulse = wr_q & ~wr_now;
  assign hp.rd_act = rd_now;
  assign hp.rd_start = rd_now & ~rd_q;
  // Writes are taken at the trailing edge, when the data lines have settled.
  assign hp.wr_pulse = wr_pulse;
  assign hp.addr = wr_pulse ? wr_hold[10:8] : sync[10:8];
  assign hp.wdata = wr_hold[7:0];
endmodule : rtd_host_port
`default_nettype wire

// File: sim/rtd_props.sv
// Port-level assertions for the touch digitizer top.
`timescale 1ns/10ps
`default_nettype none
module rtd_props (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic int_out,
  input wire logic touch_n,
  input wire logic touch_sense,
  input wire logic adc_req,
  input wire logic adc_sel_y,
  input wire logic adc_done
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_oe_on_read: assert property (data_oe |-> $past(!cs_n && !rd_n, 3))
    else $error("data lines driven outside a selected read");
  a_idle_data_zero: assert property (!data_oe |-> data_out == 8'h00)
    else $error("read data not zero while idle");
  // The interrupt may only fall after a recent selected access.
  a_int_held_high: assert property ($fell(int_out) |->
    !$past(cs_n, 3) || !$past(cs_n, 4) || !$past(cs_n, 5))
    else $error("interrupt dropped without an access");
  a_touch_low: assert property (touch_sense [*6] |-> !touch_n)
    else $error("touch output not low while touched");
  a_touch_high: assert property (!touch_sense [*6] |-> touch_n)
    else $error("touch output not high while untouched");
  a_y_after_x: assert property ($rose(adc_sel_y) |-> adc_req && $past(adc_done))
    else $error("Y conversion not preceded by X result");
  a_y_ends_conv: assert property (adc_done && adc_sel_y |=> !adc_req)
    else $error("conversion request kept after Y result");
  a_settle_gap: assert property ($fell(adc_req) |-> !adc_req [*8])
    else $error("new conversion started without settling");
  a_conv_on_touch: assert property ($rose(adc_req) |-> $past(touch_sense, 3))
    else $error("conversion started without a touch");
endmodule : rtd_props
bind rtd_top rtd_props u_props (.sys_clk, .rst_n, .cs_n, .rd_n, .data_out, .data_oe,
  .int_out, .touch_n, .touch_sense, .adc_req, .adc_sel_y, .adc_done);
`default_nettype wire

// File: sim/rtd_adc_model.sv
// Behavioural converter answering X and Y requests after a set latency.
`timescale 1ns/10ps
`default_nettype none
module rtd_adc_model (
  input wire logic sys_clk,
  input wire logic adc_req,
  input wire logic adc_sel_y,
  input wire logic [7:0] lat,
  input wire logic [11:0] x_val,
  input wire logic [11:0] y_val,
  output logic adc_done,
  output logic [11:0] adc_data
);
  int cnt = 0;
  logic wait_sel = 1'b0;
  logic done_sel = 1'b0;
  initial adc_done = 1'b0;
  initial adc_data = 12'hA5A;
  // Result bus toggles outside the done pulse so a stale capture shows up.
  always @(posedge sys_clk) begin
    adc_done <= 1'b0;
    adc_data <= ~adc_data;
    if (!adc_req) begin
      cnt <= 0;
      wait_sel <= 1'b0;
    end else if (wait_sel) begin
      if (adc_sel_y != done_sel) wait_sel <= 1'b0;
    end else if (cnt >= lat) begin
      adc_done <= 1'b1;
      adc_data <= adc_sel_y ? y_val : x_val;
      done_sel <= adc_sel_y;
      wait_sel <= 1'b1;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : rtd_adc_model
`default_nettype wire

// File: sim/tb_rtd_top.sv
// Self-checking bench for the touch digitizer top.
`timescale 1ns/10ps
`default_nettype none
module tb_rtd_top;
  logic sys_clk = 1'b0, rst_n = 1'b0, cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1;
  logic touch = 1'b0, oe, irq, tn, req, sel, done;
  logic [2:0] a = 3'h0;
  logic [7:0] din = 8'h00, dout, lat = 8'h02;
  logic [11:0] adata, xv = 12'h000, yv = 12'h000;
  int err_count = 0, tests_run = 0;
  integer seed = 37270;
  int mreg [8];
  always #50 sys_clk = ~sys_clk;
  rtd_top #(.SETTLE_CYC(50)) dut_u (.sys_clk, .rst_n, .cs_n, .rd_n, .wr_n,
    .reg_sel_hi(a[2]), .reg_sel_mid(a[1]), .reg_sel_lo(a[0]), .data_in(din),
    .data_out(dout), .data_oe(oe), .int_out(irq), .touch_n(tn), .touch_sense(touch),
    .adc_req(req), .adc_sel_y(sel), .adc_done(done), .adc_data(adata));
  rtd_adc_model adc_u (.sys_clk, .adc_req(req), .adc_sel_y(sel), .lat, .x_val(xv),
    .y_val(yv), .adc_done(done), .adc_data(adata));
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #10;
  endtask : tick
  task automatic bus_wr(input logic [2:0] ad, input logic [7:0] d);
    a = ad;
    din = d;
    cs_n = 1'b0;
    wr_n = 1'b0;
    tick(4);
    cs_n = 1'b1;
    wr_n = 1'b1;
    tick(5);
    if (ad > 3) mreg[ad] = d;
  endtask : bus_wr
  task automatic rd_chk(input int ad);
    int n;
    n = 0;
    a = 3'(ad);
    cs_n = 1'b0;
    rd_n = 1'b0;
    tick(1);
    while (oe !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    chk("read oe", 8'h01, {7'h00, oe});
    chk("reg read", 8'(mreg[ad]) | ((ad == 1 && touch) ? 8'h10 : 8'h00), dout);
    cs_n = 1'b1;
    rd_n = 1'b1;
    tick(4);
  endtask : rd_chk
  task automatic wait_irq;
    for (int n = 0; n < 500 && irq !== 1'b1; n++) tick(1);
  endtask : wait_irq
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  initial begin
    #2000000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    tick(3);
    rst_n = 1'b1;
    foreach (mreg[i]) mreg[i] = 0;
    mreg[7] = 8'h20;
    for (int i = 0; i < 8; i++) rd_chk(i);
    // Rate stays at nine or more because lower counts are not permitted.
    for (int i = 0; i < 8; i++) bus_wr(3'(i), (i == 7) ? 8'(9 + {$random(seed)} % 247)
      : 8'($random(seed)));
    for (int i = 0; i < 8; i++) rd_chk(i);
    bus_wr(3'h6, 8'h00);
    a = 3'h4;
    din = ~8'(mreg[4]);
    wr_n = 1'b0;
    rd_n = 1'b0;
    tick(5);
    chk("oe without select", 8'h00, {7'h00, oe});
    wr_n = 1'b1;
    rd_n = 1'b1;
    tick(5);
    rd_chk(4);
    for (int k = 0; k < 2; k++) begin
      lat = k ? 8'h1E : 8'h02;
      xv = 12'($random(seed));
      yv = 12'($random(seed));
      touch = 1'b1;
      bus_wr(3'h6, k ? 8'h83 : 8'h43);
      wait_irq();
      tick(10);
      chk("conv int", 8'h01, {7'h00, irq});
      chk("touch low", 8'h00, {7'h00, tn});
      mreg[0] = xv[7:0];
      mreg[1] = {4'h0, xv[11:8]};
      mreg[2] = yv[7:0];
      mreg[3] = {4'h0, yv[11:8]};
      for (int i = 0; i < 4; i++) rd_chk(i);
      chk("read clears", 8'h00, {7'h00, irq});
      touch = 1'b0;
      tick(100);
      chk("touch high", 8'h01, {7'h00, tn});
      chk("idle req", 8'h00, {7'h00, req});
      bus_wr(3'h6, 8'h00);
    end
    for (int k = 2; k < 4; k++) begin
      bus_wr(3'h6, 8'(1 << k));
      touch = ~touch;
      wait_irq();
      chk("touch change int", 8'h01, {7'h00, irq});
      bus_wr(3'h6, 8'h00);
      chk("power-down clears", 8'h00, {7'h00, irq});
    end
    touch = 1'b1;
    tick(200);
    chk("disabled req", 8'h00, {6'h00, req, irq});
    tally_and_finish();
  end
endmodule : tb_rtd_top
`default_nettype wire
